// ### dv/sdos_checker.sv
// port assertions for the expedited service-data server
// assumes it is bound onto sdos_server; one clock, reset high
`timescale 1ns/1ps
module sdos_checker (
	input wire logic        CLOCK,
	input wire logic        RST,
	input wire logic [6:0]  STATION_NUMBER,
	input wire logic        FAULT_STATE,
	input wire logic        RX_VALID,
	input wire logic [10:0] RX_ID,
	input wire logic [3:0]  RX_DLC,
	input wire logic [63:0] RX_DATA,
	input wire logic        TX_READY,
	input wire logic        RX_READY,
	input wire logic        TX_VALID,
	input wire logic [10:0] TX_ID,
	input wire logic [3:0]  TX_DLC,
	input wire logic [63:0] TX_DATA,
	input wire logic        OD_REQ,
	input wire logic        OD_WRITE,
	input wire logic [15:0] OD_INDEX,
	input wire logic [7:0]  OD_SUBINDEX,
	input wire logic [31:0] OD_WDATA,
	input wire logic [2:0]  OD_WLEN,
	input wire logic        OD_ACK,
	input wire logic [3:0]  OD_STATUS,
	input wire logic [2:0]  OD_RLEN,
	input wire logic        BAD_STATION
);
	default clocking cb @(posedge CLOCK); endclocking
	default disable iff (RST);
	logic take;
	logic known;
	assign take = RX_VALID && RX_READY && RX_DLC == 4'h8 && STATION_NUMBER != 0
		&& RX_ID == 11'h600 + 11'(STATION_NUMBER);
	assign known = RX_DATA[7:0] inside {8'h40, 8'h2F, 8'h2B, 8'h23};
	function automatic logic [7:0] rd_cmd(logic [2:0] n);
		return n == 3'h4 ? 8'h43 : (n == 3'h2 ? 8'h4B : 8'h4F);
	endfunction
	reply_id_a: assert property (TX_VALID |-> TX_DLC == 4'h8
		&& TX_ID == 11'h580 + 11'(STATION_NUMBER)) else $error("reply id");
	reply_hold_a: assert property (TX_VALID && !TX_READY |=>
		TX_VALID && $stable(TX_DATA)) else $error("reply not held");
	one_busy_a: assert property (RX_VALID && RX_READY |=> !RX_READY)
		else $error("second request taken");
	bad_cmd_a: assert property (take && !known |-> ##2 TX_VALID &&
		TX_DATA == {sdos_pkg::AB_BAD_CMD, $past(RX_DATA[31:8], 2), 8'h80})
		else $error("unknown command reply");
	od_pulse_a: assert property (take && known && !FAULT_STATE |=>
		OD_REQ ##1 !OD_REQ) else $error("store access not one pulse");
	rd_cmd_a: assert property (OD_ACK && OD_STATUS == sdos_pkg::ST_OK
		&& !OD_WRITE && OD_RLEN inside {3'h1, 3'h2, 3'h4} |-> ##3 TX_VALID
		&& TX_DATA[7:0] == rd_cmd($past(OD_RLEN, 3))) else $error("read cmd");
	wr_ack_a: assert property (OD_ACK && OD_STATUS == 4'h0 && OD_WRITE
		&& OD_WLEN == 3'h4 |-> ##3 TX_VALID && TX_DATA ==
		{OD_WDATA, OD_SUBINDEX, OD_INDEX, 8'h60}) else $error("write ack");
	station_a: assert property (STATION_NUMBER == 7'h00 |=> BAD_STATION)
		else $error("station zero not flagged");
	cover property (take ##1 OD_REQ);
	cover property (TX_VALID && TX_READY && TX_DATA[7:0] == 8'h80);
	cover property (OD_ACK && OD_WRITE);
endmodule // sdos_checker
bind sdos_server sdos_checker chk_i (
	.CLOCK          (CLOCK),
	.RST            (RST),
	.STATION_NUMBER (STATION_NUMBER),
	.FAULT_STATE    (FAULT_STATE),
	.RX_VALID       (RX_VALID),
	.RX_ID          (RX_ID),
	.RX_DLC         (RX_DLC),
	.RX_DATA        (RX_DATA),
	.TX_READY       (TX_READY),
	.RX_READY       (RX_READY),
	.TX_VALID       (TX_VALID),
	.TX_ID          (TX_ID),
	.TX_DLC         (TX_DLC),
	.TX_DATA        (TX_DATA),
	.OD_REQ         (OD_REQ),
	.OD_WRITE       (OD_WRITE),
	.OD_INDEX       (OD_INDEX),
	.OD_SUBINDEX    (OD_SUBINDEX),
	.OD_WDATA       (OD_WDATA),
	.OD_WLEN        (OD_WLEN),
	.OD_ACK         (OD_ACK),
	.OD_STATUS      (OD_STATUS),
	.OD_RLEN        (OD_RLEN),
	.BAD_STATION    (BAD_STATION)
);

// ### dv/sdos_store_model.sv
// object store stand-in: answers each access after a set delay
// assumes the bench sets status, data and length before each request
`timescale 1ns/1ps
module sdos_store_model (
	input  wire logic        clk,
	input  wire logic        rst,
	input  wire logic        req,
	input  wire logic [3:0]  dly,
	input  wire logic [3:0]  st,
	input  wire logic [31:0] rd,
	input  wire logic [2:0]  rl,
	output logic             ack,
	output logic      [3:0]  status,
	output logic      [31:0] rdata,
	output logic      [2:0]  rlen
);
	logic [3:0] cnt;
	logic       busy;
	logic       held;
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			cnt <= 4'h0;
			busy <= 1'b0;
			ack <= 1'b0;
			held <= 1'b0;
		end else begin
			held <= ack;
			ack <= busy && cnt == 4'h0;
			if (req) begin
				busy <= 1'b1;
				cnt <= dly;
			end else if (busy && cnt == 4'h0) begin
				busy <= 1'b0;
			end else if (busy) begin
				cnt <= cnt - 4'h1;
			end
		end
	end
	// inverted off the strobe so a late sample reads garbage; rlen stays true one cycle past it
	assign status = ack ? st : ~st;
	assign rdata = ack ? rd : ~rd;
	assign rlen = (ack || held) ? rl : ~rl;
endmodule // sdos_store_model

// ### dv/tb_sdos_server.sv
// bench for the expedited server: master frames in, replies checked
// assumes the store model on the dictionary side
`timescale 1ns/1ps
module tb_sdos_server;
	logic        clock = 1'b0;
	logic        rst = 1'b1;
	logic [6:0]  stn = 7'h05;
	logic        fault = 1'b0;
	logic        rx_valid = 1'b0;
	logic [10:0] rx_id = 11'h000;
	logic [3:0]  rx_dlc = 4'h0;
	logic [63:0] rx_data = 64'h0;
	logic        tx_ready = 1'b0;
	logic [3:0]  m_st = 4'h0;
	logic [3:0]  m_dly = 4'h1;
	logic [31:0] m_rd = 32'h0;
	logic [2:0]  m_rl = 3'h1;
	logic        rx_ready, tx_valid, od_req, od_wr, od_ack, bad_st;
	logic [10:0] tx_id;
	logic [3:0]  tx_dlc, od_st;
	logic [63:0] tx_data, r;
	logic [15:0] od_idx;
	logic [7:0]  od_sub;
	logic [31:0] od_wd, od_rd;
	logic [2:0]  od_wl, od_rl;
	int          n_fail = 0;
	int          cmp_count = 0;
	int          cyc = 0;
	logic [2:0]  ln [3] = '{3'h1, 3'h2, 3'h4};
	logic [7:0]  rc [3] = '{8'h4F, 8'h4B, 8'h43};
	logic [7:0]  wc [3] = '{8'h2F, 8'h2B, 8'h23};
	logic [31:0] vl [3] = '{32'hA5, 32'hC3A5, 32'h1234C3A5};
	logic [31:0] ab [13] = '{32'h06020000, 32'h06090011, 32'h06010001,
		32'h06010002, 32'h06040041, 32'h06070010, 32'h06070012, 32'h06070013,
		32'h06090030, 32'h06090031, 32'h06090032, 32'h08000022, 32'h08000022};
	always #4 clock = ~clock;
	sdos_server dut (.CLOCK(clock), .RST(rst), .STATION_NUMBER(stn),
		.FAULT_STATE(fault), .RX_VALID(rx_valid), .RX_ID(rx_id),
		.RX_DLC(rx_dlc), .RX_DATA(rx_data), .TX_READY(tx_ready),
		.RX_READY(rx_ready), .TX_VALID(tx_valid), .TX_ID(tx_id),
		.TX_DLC(tx_dlc), .TX_DATA(tx_data), .OD_REQ(od_req), .OD_WRITE(od_wr),
		.OD_INDEX(od_idx), .OD_SUBINDEX(od_sub), .OD_WDATA(od_wd),
		.OD_WLEN(od_wl), .OD_ACK(od_ack), .OD_STATUS(od_st),
		.OD_RDATA(od_rd), .OD_RLEN(od_rl), .BAD_STATION(bad_st));
	sdos_store_model store (.clk(clock), .rst(rst), .req(od_req),
		.dly(m_dly), .st(m_st), .rd(m_rd), .rl(m_rl), .ack(od_ack),
		.status(od_st), .rdata(od_rd), .rlen(od_rl));
	task chk(input logic [63:0] got, input logic [63:0] exp);
		cmp_count++;
		if (got !== exp) begin
			n_fail++;
			$display("FAIL t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	task end_sim();
		$display("compares %0d mismatches %0d", cmp_count, n_fail);
		if (n_fail == 0 && cmp_count > 0) $display("NO MISMATCHES");
		else $display("MISMATCHES SEEN");
		$finish;
	endtask
	// none set: the frame must be swallowed with no reply
	task xfer(input logic [10:0] id, input logic [3:0] dlc,
		input logic [63:0] d, input logic none);
		@(posedge clock);
		rx_valid <= 1'b1;
		rx_id <= id;
		rx_dlc <= dlc;
		rx_data <= d;
		@(negedge clock);
		while (rx_ready !== 1'b1) @(negedge clock);
		@(posedge clock);
		rx_valid <= 1'b0;
		repeat (40) begin
			@(negedge clock);
			if (tx_valid === 1'b1 && !none) break;
		end
		r = tx_data;
		if (none) chk(64'(tx_valid), 64'h0);
		else chk(64'({tx_id, tx_dlc}), 64'({11'h580 + 11'(stn), 4'h8}));
		if (!none) begin
			repeat (m_dly + 1) @(posedge clock);
			tx_ready <= 1'b1;
			@(posedge clock);
			tx_ready <= 1'b0;
		end
	endtask
	task q(input logic [7:0] c, input logic [31:0] d, input logic [63:0] e);
		xfer(11'h605, 4'h8, {d, 24'h016041, c}, 1'b0);
		chk(r, e);
	endtask
	function automatic logic [63:0] ab_f(logic [31:0] c);
		return {c, 24'h016041, 8'h80};
	endfunction
	always @(posedge clock) begin
		cyc++;
		if (cyc == 5000) begin
			n_fail++;
			end_sim();
		end
	end
	initial begin
		repeat (5) @(posedge clock);
		rst <= 1'b0;
		for (int k = 0; k < 3; k++) begin
			m_rl <= ln[k];
			m_rd <= vl[k];
			m_dly <= 4'(3 * k);
			q(8'h40, 32'hDEADBEEF, {vl[k], 24'h016041, rc[k]});
			q(wc[k], vl[k], {vl[k], 24'h016041, 8'h60});
			chk({od_idx, od_sub, od_wr, od_wl, od_wd},
				{4'h0, 16'h6041, 8'h01, 1'b1, ln[k], vl[k]});
		end
		m_rl <= 3'h3;
		q(8'h40, 32'h0, ab_f(32'h06070010));
		m_st <= 4'h3;
		q(8'h40, 32'h0, ab_f(32'h06010001));
		for (int k = 0; k < 13; k++) begin
			m_st <= 4'(k + 1);
			q(8'h23, vl[2], ab_f(ab[k]));
		end
		m_st <= 4'h0;
		fault <= 1'b1;
		q(8'h40, 32'h0, ab_f(32'h06060000));
		q(8'h20, 32'h0, ab_f(32'h05040001));
		fault <= 1'b0;
		q(8'hFF, 32'h0, ab_f(32'h05040001));
		xfer(11'h606, 4'h8, 64'h40, 1'b1);
		xfer(11'h605, 4'h4, 64'h40, 1'b1);
		@(posedge clock);
		stn <= 7'h00;
		xfer(11'h600, 4'h8, 64'h40, 1'b1);
		chk(64'(bad_st), 64'h1);
		@(posedge clock);
		stn <= 7'h05;
		repeat (2) @(posedge clock);
		chk(64'(bad_st), 64'h0);
		end_sim();
	end
endmodule // tb_sdos_server

// ### rtl/sdos_len_code.sv
// maps an access length in bytes onto command and size fields
// assumes lengths of 1, 2 or 4; anything else is flagged unsupported
`timescale 1ns/1ps
module sdos_len_code (
	input  wire logic       clk,
	input  wire logic       rst,
	input  wire logic [2:0] len,
	output logic      [7:0] rd_cmd_reg,
	output logic            len_ok_reg
);
	logic [7:0] rd_cmd_next;
	logic       len_ok_next;

	always_comb begin
		rd_cmd_next = sdos_pkg::CMD_ABORT;
		len_ok_next = 1'b1;
		case (len)
			3'h1: rd_cmd_next = sdos_pkg::CMD_RD_1B;
			3'h2: rd_cmd_next = sdos_pkg::CMD_RD_2B;
			3'h4: rd_cmd_next = sdos_pkg::CMD_RD_4B;
			default: len_ok_next = 1'b0;
		endcase
	end

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			rd_cmd_reg <= 8'h00;
			len_ok_reg <= 1'b0;
		end else begin
			rd_cmd_reg <= rd_cmd_next;
			len_ok_reg <= len_ok_next;
		end
	end
endmodule // sdos_len_code

// ### rtl/sdos_pkg.sv
// constants for the expedited service-data server
// assumes one system clock; frames arrive already filtered by the can core
package sdos_pkg;
	localparam logic [10:0] ID_REQ_BASE   = 11'h600;
	localparam logic [10:0] ID_RSP_BASE   = 11'h580;
	localparam logic [3:0]  FRAME_DLC     = 4'h8;
	localparam logic [7:0]  CMD_READ      = 8'h40;
	localparam logic [7:0]  CMD_RD_1B     = 8'h4F;
	localparam logic [7:0]  CMD_RD_2B     = 8'h4B;
	localparam logic [7:0]  CMD_RD_4B     = 8'h43;
	localparam logic [7:0]  CMD_WR_1B     = 8'h2F;
	localparam logic [7:0]  CMD_WR_2B     = 8'h2B;
	localparam logic [7:0]  CMD_WR_4B     = 8'h23;
	localparam logic [7:0]  CMD_WR_ACK    = 8'h60;
	localparam logic [7:0]  CMD_ABORT     = 8'h80;
	localparam logic [31:0] AB_BAD_CMD    = 32'h05040001;
	localparam logic [31:0] AB_WO_READ    = 32'h06010001;
	localparam logic [31:0] AB_RO_WRITE   = 32'h06010002;
	localparam logic [31:0] AB_NO_INDEX   = 32'h06020000;
	localparam logic [31:0] AB_NO_MAP     = 32'h06040041;
	localparam logic [31:0] AB_FAULT      = 32'h06060000;
	localparam logic [31:0] AB_LEN_MIS    = 32'h06070010;
	localparam logic [31:0] AB_LEN_BIG    = 32'h06070012;
	localparam logic [31:0] AB_LEN_SHORT  = 32'h06070013;
	localparam logic [31:0] AB_BAD_SUB    = 32'h06090011;
	localparam logic [31:0] AB_RANGE      = 32'h06090030;
	localparam logic [31:0] AB_TOO_BIG    = 32'h06090031;
	localparam logic [31:0] AB_TOO_SMALL  = 32'h06090032;
	localparam logic [31:0] AB_STATE      = 32'h08000022;
	// command byte field positions
	localparam int          CMD_E_BIT     = 1;
	localparam int          CMD_S_BIT     = 0;
	localparam int          CMD_N_LSB     = 2;
	// dictionary answer status codes
	localparam logic [3:0]  ST_OK         = 4'h0;
	localparam logic [3:0]  ST_NO_INDEX   = 4'h1;
	localparam logic [3:0]  ST_BAD_SUB    = 4'h2;
	localparam logic [3:0]  ST_WO         = 4'h3;
	localparam logic [3:0]  ST_RO         = 4'h4;
	localparam logic [3:0]  ST_NO_MAP     = 4'h5;
	localparam logic [3:0]  ST_LEN_MIS    = 4'h6;
	localparam logic [3:0]  ST_LEN_BIG    = 4'h7;
	localparam logic [3:0]  ST_LEN_SHORT  = 4'h8;
	localparam logic [3:0]  ST_RANGE      = 4'h9;
	localparam logic [3:0]  ST_TOO_BIG    = 4'hA;
	localparam logic [3:0]  ST_TOO_SMALL  = 4'hB;
	localparam logic [3:0]  ST_STATE      = 4'hC;
	localparam logic [6:0]  STATION_MIN   = 7'h01;
	typedef enum {S_IDLE, S_ASK, S_WAIT, S_SEND} sdos_state_t;
endpackage

// ### rtl/sdos_server.sv
// expedited service-data server: one request frame in, one reply out
// assumes the can core hands over whole frames and holds a reply until taken;
// the object store answers each access some cycles later with a status code
// station number is taken as static while a request is outstanding;
// a zero station blocks every new request until it is changed
//
// How it works
// RULE_01 - master requests use id 0x600+station, dlc 8
// RULE_02 - replies use id 0x580+station, dlc 8
// RULE_03 - command, index, subindex, little-endian data bytes
// RULE_04 - master reads with command 0x40
// RULE_05 - read reply 0x4F, 0x4B or 0x43 by size
// RULE_06 - failed read answered with 0x80
// RULE_07 - master writes with 0x2F, 0x2B, 0x23
// RULE_08 - accepted write acknowledged with 0x60
// RULE_09 - rejected write answered 0x80 with code
// RULE_10 - unknown command gives 0x05040001
// RULE_11 - wrong-direction access gives 0x0601000x codes
// RULE_12 - missing index or subindex codes
// RULE_13 - unmappable object gives 0x06040041
// RULE_14 - fault state refuses access, 0x06060000
// RULE_15 - length mismatch, too large, too short codes
// RULE_16 - range, too large, too small value codes
// RULE_17 - device state blocks transfer, 0x08000022
// RULE_18 - e/s flags and unused-byte count field
// RULE_19 - write ack echoes index, subindex, data
// RULE_20 - station number 1 to 127, never 0
// RULE_21 - read data ignored, one reply per request
// RULE_22 - abort code in bytes 4-7, lsb first
`timescale 1ns/1ps
module sdos_server (
	input  wire logic        CLOCK,
	input  wire logic        RST,
	input  wire logic [6:0]  STATION_NUMBER,
	input  wire logic        FAULT_STATE,
	input  wire logic        RX_VALID,
	input  wire logic [10:0] RX_ID,
	input  wire logic [3:0]  RX_DLC,
	input  wire logic [63:0] RX_DATA,
	input  wire logic        TX_READY,
	output logic             RX_READY,
	output logic             TX_VALID,
	output logic      [10:0] TX_ID,
	output logic      [3:0]  TX_DLC,
	output logic      [63:0] TX_DATA,
	output logic             OD_REQ,
	output logic             OD_WRITE,
	output logic      [15:0] OD_INDEX,
	output logic      [7:0]  OD_SUBINDEX,
	output logic      [31:0] OD_WDATA,
	output logic      [2:0]  OD_WLEN,
	input  wire logic        OD_ACK,
	input  wire logic [3:0]  OD_STATUS,
	input  wire logic [31:0] OD_RDATA,
	input  wire logic [2:0]  OD_RLEN,
	output logic             BAD_STATION
);
	sdos_pkg::sdos_state_t state_reg, state_next;
	logic        rx_ready_reg, rx_ready_next;
	logic        tx_valid_reg, tx_valid_next;
	logic [10:0] tx_id_reg, tx_id_next;
	logic [63:0] tx_data_reg, tx_data_next;
	logic        od_req_reg, od_req_next;
	logic        od_write_reg, od_write_next;
	logic [15:0] index_reg, index_next;
	logic [7:0]  sub_reg, sub_next;
	logic [31:0] wdata_reg, wdata_next;
	logic [2:0]  wlen_reg, wlen_next;
	logic        bad_st_reg, bad_st_next;
	logic [7:0]  rd_cmd;
	logic        rlen_ok;

	// registered length decode; OD_RLEN is held by the store with OD_ACK
	sdos_len_code u_len (
		.clk        (CLOCK),
		.rst        (RST),
		.len        (OD_RLEN),
		.rd_cmd_reg (rd_cmd),
		.len_ok_reg (rlen_ok)
	);

	logic [7:0]  rx_cmd;
	logic [15:0] rx_index;
	logic [7:0]  rx_sub;
	logic [31:0] rx_val;
	logic [2:0]  rx_len;
	logic [1:0]  rx_pad;
	logic        rx_exp;
	logic        rx_sized;
	logic        rx_is_wr;
	logic        rx_known;
	logic        rx_ours;

	always_comb begin
		rx_cmd   = RX_DATA[7:0];
		rx_index = RX_DATA[23:8];                                  // RULE_03
		rx_sub   = RX_DATA[31:24];
		rx_val   = RX_DATA[63:32];
		rx_exp   = rx_cmd[sdos_pkg::CMD_E_BIT];
		rx_sized = rx_cmd[sdos_pkg::CMD_S_BIT];
		rx_pad   = rx_cmd[sdos_pkg::CMD_N_LSB +: 2];
		rx_is_wr = 1'b0;
		rx_known = 1'b1;
		rx_len   = 3'h4;
		// only whole known command bytes pass, so a reserved flag pair
		// can never reach the store through the size field alone
		case (rx_cmd)                                              // RULE_18
			sdos_pkg::CMD_WR_1B,
			sdos_pkg::CMD_WR_2B,
			sdos_pkg::CMD_WR_4B: begin                             // RULE_07
				// e and s set: n trailing bytes are padding, 4-n carry data
				rx_is_wr = rx_exp && rx_sized;
				rx_len   = 3'h4 - {1'b0, rx_pad};
			end
			sdos_pkg::CMD_READ:  rx_len = 3'h0;                    // RULE_04
			default:             rx_known = 1'b0;
		endcase
		rx_ours = (RX_ID == 11'(sdos_pkg::ID_REQ_BASE + 11'(STATION_NUMBER)))
			&& (RX_DLC == sdos_pkg::FRAME_DLC)                     // RULE_01
			&& !bad_st_reg;                                        // RULE_20
	end

	function automatic logic [31:0] abort_of(input logic [3:0] st);
		case (st)
			sdos_pkg::ST_NO_INDEX:  abort_of = sdos_pkg::AB_NO_INDEX;
			sdos_pkg::ST_BAD_SUB:   abort_of = sdos_pkg::AB_BAD_SUB;  // RULE_12
			sdos_pkg::ST_WO:        abort_of = sdos_pkg::AB_WO_READ;
			sdos_pkg::ST_RO:        abort_of = sdos_pkg::AB_RO_WRITE; // RULE_11
			sdos_pkg::ST_NO_MAP:    abort_of = sdos_pkg::AB_NO_MAP;   // RULE_13
			sdos_pkg::ST_LEN_MIS:   abort_of = sdos_pkg::AB_LEN_MIS;
			sdos_pkg::ST_LEN_BIG:   abort_of = sdos_pkg::AB_LEN_BIG;
			sdos_pkg::ST_LEN_SHORT: abort_of = sdos_pkg::AB_LEN_SHORT; // RULE_15
			sdos_pkg::ST_RANGE:     abort_of = sdos_pkg::AB_RANGE;
			sdos_pkg::ST_TOO_BIG:   abort_of = sdos_pkg::AB_TOO_BIG;
			sdos_pkg::ST_TOO_SMALL: abort_of = sdos_pkg::AB_TOO_SMALL; // RULE_16
			default:                abort_of = sdos_pkg::AB_STATE;     // RULE_17
		endcase
	endfunction

	function automatic logic [63:0] abort_frame(input logic [15:0] idx,
			input logic [7:0] sub, input logic [31:0] code);
		abort_frame = {code, sub, idx, sdos_pkg::CMD_ABORT};       // RULE_22
	endfunction

	// the store's answer is taken one cycle late so the length decode settles
	logic        ack_d_reg, ack_d_next;
	logic [3:0]  st_d_reg, st_d_next;
	logic [31:0] rd_d_reg, rd_d_next;

	always_comb begin
		// a stray acknowledge outside the wait state is dropped here
		ack_d_next = OD_ACK && state_reg == sdos_pkg::S_WAIT;
		st_d_next  = OD_STATUS;
		rd_d_next  = OD_RDATA;
	end

	always_ff @(posedge CLOCK or posedge RST) begin
		if (RST) begin
			ack_d_reg <= 1'b0;
			st_d_reg  <= 4'h0;
			rd_d_reg  <= 32'h0;
		end else begin
			ack_d_reg <= ack_d_next;
			st_d_reg  <= st_d_next;
			rd_d_reg  <= rd_d_next;
		end
	end

	always_comb begin
		state_next    = state_reg;
		rx_ready_next = 1'b0;
		tx_valid_next = tx_valid_reg;
		tx_id_next    = tx_id_reg;
		tx_data_next  = tx_data_reg;
		od_req_next   = 1'b0;
		od_write_next = od_write_reg;
		index_next    = index_reg;
		sub_next      = sub_reg;
		wdata_next    = wdata_reg;
		wlen_next     = wlen_reg;
		case (state_reg)
			sdos_pkg::S_IDLE: begin
				// every frame taken drops ready for at least one cycle; frames for
				// other stations are swallowed without a reply
				rx_ready_next = !(RX_VALID && rx_ready_reg);
				if (RX_VALID && rx_ready_reg && rx_ours) begin
					index_next    = rx_index;
					sub_next      = rx_sub;
					od_write_next = rx_is_wr;
					// read data bytes are don't-care
					wdata_next    = rx_is_wr ? rx_val : 32'h0;   // RULE_21
					wlen_next     = rx_len;
					tx_id_next    = 11'(sdos_pkg::ID_RSP_BASE
						+ 11'(STATION_NUMBER));                    // RULE_02
					if (!rx_known) begin
						tx_data_next = abort_frame(rx_index, rx_sub,
							sdos_pkg::AB_BAD_CMD);                 // RULE_10
						state_next   = sdos_pkg::S_SEND;
					end else if (FAULT_STATE) begin
						tx_data_next = abort_frame(rx_index, rx_sub,
							sdos_pkg::AB_FAULT);                   // RULE_14
						state_next   = sdos_pkg::S_SEND;
					end else begin
						od_req_next  = 1'b1;
						state_next   = sdos_pkg::S_WAIT;
					end
				end
			end
			sdos_pkg::S_WAIT: begin
				if (ack_d_reg) begin
					state_next = sdos_pkg::S_SEND;
					if (st_d_reg != sdos_pkg::ST_OK) begin
						tx_data_next = abort_frame(index_reg, sub_reg,
							abort_of(st_d_reg));                   // RULE_06 RULE_09
					end else if (od_write_reg) begin
						tx_data_next = {wdata_reg, sub_reg, index_reg,
							sdos_pkg::CMD_WR_ACK};                 // RULE_08 RULE_19
					// a store length other than 1, 2 or 4 has no reply code
					end else if (!rlen_ok) begin
						tx_data_next = abort_frame(index_reg, sub_reg,
							sdos_pkg::AB_LEN_MIS);                 // RULE_06
					end else begin
						tx_data_next = {rd_d_reg, sub_reg, index_reg,
							rd_cmd};                               // RULE_05
					end
				end
			end
			sdos_pkg::S_SEND: begin
				tx_valid_next = 1'b1;
				state_next    = sdos_pkg::S_ASK;
			end
			sdos_pkg::S_ASK: begin
				// exactly one reply; next request only after it is taken
				if (tx_valid_reg && TX_READY) begin                // RULE_21
					tx_valid_next = 1'b0;
					rx_ready_next = 1'b1;
					state_next    = sdos_pkg::S_IDLE;
				end
			end
			default: state_next = sdos_pkg::S_IDLE;
		endcase
	end

	always_ff @(posedge CLOCK or posedge RST) begin
		if (RST) begin
			state_reg    <= sdos_pkg::S_IDLE;
			rx_ready_reg <= 1'b0;
			tx_valid_reg <= 1'b0;
			tx_id_reg    <= 11'h000;
			tx_data_reg  <= 64'h0;
			od_req_reg   <= 1'b0;
			od_write_reg <= 1'b0;
			index_reg    <= 16'h0000;
			sub_reg      <= 8'h00;
			wdata_reg    <= 32'h0;
			wlen_reg     <= 3'h0;
		end else begin
			state_reg    <= state_next;
			rx_ready_reg <= rx_ready_next;
			tx_valid_reg <= tx_valid_next;
			tx_id_reg    <= tx_id_next;
			tx_data_reg  <= tx_data_next;
			od_req_reg   <= od_req_next;
			od_write_reg <= od_write_next;
			index_reg    <= index_next;
			sub_reg      <= sub_next;
			wdata_reg    <= wdata_next;
			wlen_reg     <= wlen_next;
		end
	end

	// station check and reply length code: a zero station blocks every
	// take from the cycle after it appears, and reset keeps it blocked
	logic [3:0] tx_dlc_reg, tx_dlc_next;

	always_comb begin
		bad_st_next = (STATION_NUMBER < sdos_pkg::STATION_MIN);   // RULE_20
		tx_dlc_next = sdos_pkg::FRAME_DLC;                         // RULE_02
	end

	always_ff @(posedge CLOCK or posedge RST) begin
		if (RST) begin
			bad_st_reg <= 1'b1;
			tx_dlc_reg <= 4'h0;
		end else begin
			bad_st_reg <= bad_st_next;
			tx_dlc_reg <= tx_dlc_next;
		end
	end

	assign RX_READY    = rx_ready_reg;
	assign TX_VALID    = tx_valid_reg;
	assign TX_ID       = tx_id_reg;
	assign TX_DLC      = tx_dlc_reg;
	assign TX_DATA     = tx_data_reg;
	assign OD_REQ      = od_req_reg;
	assign OD_WRITE    = od_write_reg;
	assign OD_INDEX    = index_reg;
	assign OD_SUBINDEX = sub_reg;
	assign OD_WDATA    = wdata_reg;
	assign OD_WLEN     = wlen_reg;
	assign BAD_STATION = bad_st_reg;
endmodule // sdos_server
